// ===== pspc_core.sv
// Phase shift power control: state sequencing, coil cell, loop and limiter
`timescale 1ns/1ps
// Summary of operation
// RL1: Attach one coil or two overlapping coils.
// RL2: Inverter period kept within 125-135 kHz.
// RL3: Ping: damping closed, transition open.
// RL4: Power transfer: both switches open.
// RL5: Transition closes transition switch before resonance.
// RL6: Phase 0 to 180 degrees sets power.
// RL7: Phase steps finer than 0.42 degrees.
// RL8: Start at 180 degrees, damped ping switches.
// RL9: Loop controls the half-bridge phase.
// RL10: Current measured in 1 mA units.
// RL11: Current cap 5 A dual, 3 A single.
// RL12: Gain one, output limit 2000, 0.01 degree.
// RL13: One instance serves one receiver only.
// RL14: Never attach a coil another inverter holds.
// RL15: Equal 50 percent waves, update at boundaries.
// RL16: Over cap, phase is reduced regardless.
module pspc_core
  import pspc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 power_en,
  input  wire pspc_pkg::pspc_req_e  mode_req,
  input  wire logic [PER_W-1:0]     period_cycles,
  input  wire pspc_pkg::pspc_cell_s cell_req,
  input  wire logic [COILS-1:0]     coil_busy,
  input  wire logic [CUR_W-1:0]     target_ma,
  input  wire pspc_pkg::pspc_meas_s meas,
  output logic                      bridge_a_q,
  output logic                      bridge_b_q,
  output logic [1:0]                bridge_b_fine_q,
  output logic                      damping_switch_q,
  output logic                      transition_switch_q,
  output logic [COILS-1:0]          coil_en_q,
  output logic [PH_W-1:0]           phase_q,
  output logic                      limit_active_q
);

  typedef enum logic [2:0] {PSPC_OFF, PSPC_PING, PSPC_TRANS, PSPC_XFER} pspc_state_e;

  pspc_state_e      state_q;
  pspc_state_e      state_d;
  logic [PER_W-1:0] dwell_q;
  logic             run_q;

  //////////////////////////////////////////////////////////////////////////////
  // State sequencing

  wire dwell_done = (dwell_q == '0);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PSPC_OFF:   if (power_en) state_d = PSPC_PING;                       // [RL8]
      PSPC_PING:  if (mode_req != PSPC_REQ_PING) state_d = PSPC_TRANS;     // [RL5]
      PSPC_TRANS: begin
        if (mode_req == PSPC_REQ_PING) begin
          state_d = PSPC_PING;
        end else if (mode_req == PSPC_REQ_XFER && dwell_done) begin
          state_d = PSPC_XFER;
        end
      end
      PSPC_XFER:  if (mode_req != PSPC_REQ_XFER) state_d = PSPC_TRANS;
      default:    state_d = PSPC_OFF;
    endcase
    if (!power_en) state_d = PSPC_OFF;
  end

  wire sw_damp  = (state_q == PSPC_OFF) || (state_q == PSPC_PING)
                  || (state_q == PSPC_TRANS);                              // [RL3] [RL4]
  wire sw_trans = (state_q == PSPC_TRANS);                                 // [RL5]

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q             <= PSPC_OFF;
      dwell_q             <= '0;
      run_q               <= 1'b0;
      damping_switch_q    <= 1'b1;
      transition_switch_q <= 1'b0;
    end else begin
      state_q             <= state_d;
      dwell_q             <= (state_d == PSPC_TRANS && state_q != PSPC_TRANS) ? TRANS_CYCLES :
                             (dwell_done ? dwell_q : dwell_q - 1'b1);
      run_q               <= (state_d != PSPC_OFF);
      damping_switch_q    <= sw_damp;
      transition_switch_q <= sw_trans;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coil cell selection

  logic [COILS-1:0] cell_mask;
  genvar gi;
  generate
    for (gi = 0; gi < COILS; gi++) begin : g_cell
      assign cell_mask[gi] = (cell_req.index == CIDX_W'(gi)) ||
                             (cell_req.pair && gi > 0 &&
                              cell_req.index == CIDX_W'(gi - 1));          // [RL1]
    end
  endgenerate

  wire cell_free  = ((cell_mask & coil_busy) == '0);                       // [RL14]
  wire cell_dual  = cell_req.pair && (cell_req.index != CIDX_W'(COILS - 1));
  logic dual_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      coil_en_q <= '0;
      dual_q    <= 1'b0;
    end else begin
      coil_en_q <= (run_q && cell_free) ? cell_mask : '0;                  // [RL14] [RL13]
      dual_q    <= cell_dual;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Loop and current limiter

  wire [CUR_W-1:0]  cap_ma    = dual_q ? CAP_DUAL_MA : CAP_SINGLE_MA;      // [RL11]
  wire              over_cap  = meas.rms_ma > cap_ma;                      // [RL10]
  wire signed [17:0] err      = $signed({2'b00, target_ma}) - $signed({2'b00, meas.rms_ma});
  wire signed [33:0] p_term   = 34'(err) * $signed({18'h0_0000, KP_PER_MA}); // [RL12]
  wire signed [17:0] lim      = $signed({2'b00, LOOP_OUTPUT_LIMIT});
  wire signed [17:0] loop_out = (p_term > 34'(lim))  ? lim :
                                (p_term < -34'(lim)) ? -lim : p_term[17:0]; // [RL12]
  wire signed [17:0] ph_sum   = $signed({3'b000, phase_q}) + loop_out;     // [RL9]
  wire [PH_W-1:0]    ph_loop  = (ph_sum < 0) ? '0 :
                                (ph_sum > $signed({3'b000, PHASE_MAX})) ? PHASE_MAX :
                                ph_sum[PH_W-1:0];                          // [RL6]
  wire [PH_W-1:0]    ph_cut   = (phase_q > LIMIT_STEP) ? phase_q - LIMIT_STEP : '0;

  always_ff @(posedge core_clk) begin
    if (sys_rst || state_q == PSPC_OFF) begin
      phase_q        <= PHASE_INIT;                                        // [RL8]
      limit_active_q <= 1'b0;
    end else if (meas.valid) begin
      phase_q        <= over_cap ? ph_cut : ph_loop;                       // [RL16] [RL9]
      limit_active_q <= over_cap;                                          // [RL16]
    end
  end

  pspc_bridge_gen u_bridge (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .run          (run_q),
    .period       (period_cycles),
    .phase        (phase_q),
    .leg_a_q      (bridge_a_q),
    .leg_b_q      (bridge_b_q),
    .leg_b_fine_q (bridge_b_fine_q),
    .boundary_q   ()
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_start;
    state_q == PSPC_OFF ##1 state_q == PSPC_PING;
  endsequence

  start_state_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL8]
    s_start |-> (phase_q == PHASE_INIT) ##1 (damping_switch_q && !transition_switch_q))
    else $error("start not at full phase with damped switches");

  ping_switch_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL3]
    state_q == PSPC_PING |=> damping_switch_q && !transition_switch_q)
    else $error("ping switch setting wrong");

  xfer_switch_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL4]
    state_q == PSPC_XFER |=> !damping_switch_q && !transition_switch_q)
    else $error("transfer switch setting wrong");

  trans_path_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL5]
    (state_q == PSPC_PING ##1 state_q == PSPC_TRANS) |-> state_q != PSPC_XFER [*8])
    else $error("transition dwell skipped");

  phase_range_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL6]
    phase_q <= PHASE_MAX)
    else $error("phase above 180 degrees");

  loop_step_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL12]
    (meas.valid && state_q != PSPC_OFF && !over_cap) |=>
      ($past(phase_q) + LIMIT_STEP >= phase_q && phase_q + LIMIT_STEP >= $past(phase_q)))
    else $error("loop step beyond output limit");

  cap_cut_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL16]
    (meas.valid && over_cap && state_q != PSPC_OFF && phase_q != '0) |=>
      (phase_q < $past(phase_q)) && limit_active_q)
    else $error("over-cap current did not reduce phase");

  coil_share_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL14]
    (coil_en_q & $past(coil_busy)) == '0)
    else $error("coil attached while held by another inverter");

  coil_count_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL1]
    $countones(coil_en_q) <= 2)
    else $error("more than two coils attached");

endmodule

// ===== pspc_pkg.sv
// Shared constants and carrier types for the phase shift power control block
package pspc_pkg;

  // Clock and operating frequency
  localparam int CLK_KHZ      = 100000;
  localparam int FOP_MIN_KHZ  = 125;
  localparam int FOP_MAX_KHZ  = 135;
  localparam int PER_W        = 10;
  localparam logic [PER_W-1:0] PERIOD_MAX = PER_W'(CLK_KHZ / FOP_MIN_KHZ);
  localparam logic [PER_W-1:0] PERIOD_MIN =
    PER_W'((CLK_KHZ + FOP_MAX_KHZ - 1) / FOP_MAX_KHZ);

  // Phase in hundredths of a degree
  localparam int PH_W = 15;
  localparam logic [PH_W-1:0] PHASE_MAX  = 15'h4650;
  localparam logic [PH_W-1:0] PHASE_INIT = 15'h4650;

  // Quarter-cycle delay: phase * period / 9000, 2^24 reciprocal of 9000
  localparam int  RECIP_SHIFT = 24;
  localparam logic [10:0] RECIP_9000 = 11'h0748;
  localparam int  DLY_W = 12;

  // Loop values
  localparam int CUR_W = 16;
  localparam logic [CUR_W-1:0] LOOP_OUTPUT_LIMIT = 16'h07D0;
  localparam logic [CUR_W-1:0] KP_PER_MA         = 16'h0001;
  localparam logic [CUR_W-1:0] CAP_DUAL_MA       = 16'h1388;
  localparam logic [CUR_W-1:0] CAP_SINGLE_MA     = 16'h0BB8;
  localparam logic [PH_W-1:0]  LIMIT_STEP        = 15'h07D0;

  // Coil array
  localparam int COILS = 8;
  localparam int CIDX_W = 3;

  // Transition dwell, one longest period
  localparam logic [PER_W-1:0] TRANS_CYCLES = PERIOD_MAX;

  typedef enum logic [1:0] {PSPC_REQ_PING, PSPC_REQ_TRANS, PSPC_REQ_XFER} pspc_req_e;

  typedef struct packed {
    logic             valid;
    logic [CUR_W-1:0] rms_ma;
  } pspc_meas_s;

  typedef struct packed {
    logic              pair;
    logic [CIDX_W-1:0] index;
  } pspc_cell_s;

endpackage

// ===== pspc_bridge_gen.sv
// Two 50 percent square waves with a programmable phase delay
`timescale 1ns/1ps
module pspc_bridge_gen
  import pspc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              run,
  input  wire logic [PER_W-1:0]  period,
  input  wire logic [PH_W-1:0]   phase,
  output logic                   leg_a_q,
  output logic                   leg_b_q,
  output logic [1:0]             leg_b_fine_q,
  output logic                   boundary_q
);

  logic [PER_W-1:0] cnt_q;
  logic [PER_W-1:0] per_q;
  logic [DLY_W-1:0] dly_q;

  wire [PER_W-1:0] per_clamp = (period < PERIOD_MIN) ? PERIOD_MIN :
                               (period > PERIOD_MAX) ? PERIOD_MAX : period;
  wire [35:0]      dly_prod  = 36'(phase) * 36'(per_clamp) * 36'(RECIP_9000);
  wire [DLY_W-1:0] dly_new   = dly_prod[RECIP_SHIFT +: DLY_W];
  wire             wrap      = (cnt_q == per_q - 1'b1);
  wire [PER_W-1:0] coarse    = dly_q[DLY_W-1:2];
  wire [PER_W:0]   b_pos     = {1'b0, cnt_q} + {1'b0, per_q} - {1'b0, coarse};
  wire [PER_W:0]   b_mod     = (b_pos >= {1'b0, per_q}) ? b_pos - {1'b0, per_q} : b_pos;
  wire [PER_W-1:0] half      = per_q >> 1;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q      <= '0;
      per_q      <= PERIOD_MAX;
      dly_q      <= '0;
      boundary_q <= 1'b0;
    end else if (!run) begin
      cnt_q      <= '0;
      per_q      <= per_clamp;                          // [RL2]
      dly_q      <= dly_new;                            // [RL8]
      boundary_q <= 1'b0;
    end else begin
      cnt_q      <= wrap ? '0 : cnt_q + 1'b1;
      boundary_q <= wrap;
      if (wrap) begin
        per_q <= per_clamp;                          // [RL2]
        dly_q <= dly_new;                            // [RL15] [RL7]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !run) begin
      leg_a_q      <= 1'b0;
      leg_b_q      <= 1'b0;
      leg_b_fine_q <= 2'h0;
    end else begin
      leg_a_q      <= (cnt_q < half);                // [RL15]
      leg_b_q      <= (b_mod[PER_W-1:0] < half);     // [RL6]
      leg_b_fine_q <= dly_q[1:0];                    // [RL7]
    end
  end

  period_range_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL2]
    run |-> (per_q >= PERIOD_MIN && per_q <= PERIOD_MAX))
    else $error("bridge period outside operating range");

  delay_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [RL15]
    (run && $past(run) && !$past(wrap)) |-> $stable(dly_q))
    else $error("phase delay changed inside a period");

endmodule

// ===== pspc_sense_model.sv
// Coil-cell current sensing model
`timescale 1ns/1ps
module pspc_sense_model (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      take,
  input  wire logic [pspc_pkg::CUR_W-1:0] level_ma,
  output pspc_pkg::pspc_meas_s           meas
);
  import pspc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // One-cycle result pulse; value line scrambles when idle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meas <= '0;
    end else begin
      meas.valid  <= take;
      meas.rms_ma <= take ? level_ma : ~meas.rms_ma;
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking testbench for the phase shift power control core
`timescale 1ns/1ps
module tb_top;
  import pspc_pkg::*;
  logic             core_clk, sys_rst, power_en, take;
  pspc_req_e        mode_req;
  logic [PER_W-1:0] period_cycles;
  pspc_cell_s       cell_req;
  logic [COILS-1:0] coil_busy, coil_en_q;
  logic [CUR_W-1:0] target_ma, level_ma;
  pspc_meas_s       meas;
  logic             bridge_a_q, bridge_b_q, damping_switch_q;
  logic             transition_switch_q, limit_active_q;
  logic [1:0]       bridge_b_fine_q;
  logic [PH_W-1:0]  phase_q;
  int               err_total, checked, hi, dly;

  pspc_core dut (.core_clk, .sys_rst, .power_en, .mode_req, .period_cycles,
    .cell_req, .coil_busy, .target_ma, .meas, .bridge_a_q, .bridge_b_q,
    .bridge_b_fine_q, .damping_switch_q, .transition_switch_q, .coil_en_q,
    .phase_q, .limit_active_q);
  pspc_sense_model sense_m (.core_clk, .sys_rst, .take, .level_ma, .meas);

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic sense(input logic [CUR_W-1:0] v);
    @(posedge core_clk);
    take     <= 1'b1;
    level_ma <= v;
    @(posedge core_clk);
    take <= 1'b0;
    tick(3);
  endtask

  task automatic step(input logic pr, input logic [15:0] tg, input logic [15:0] rms,
                      input logic [14:0] ph, input logic lim);
    @(posedge core_clk);
    cell_req.pair <= pr;
    target_ma     <= tg;
    sense(rms);
    check(phase_q, ph);
    check(limit_active_q, lim);
  endtask

  // High time of leg A and leg B low time inside it
  task automatic edges;
    int n;
    #1;
    n   = 0;
    hi  = 0;
    dly = 0;
    while (bridge_a_q !== 1'b0 && n < 2000) begin tick(1); n++; end
    while (bridge_a_q !== 1'b1 && n < 4000) begin tick(1); n++; end
    while (bridge_a_q === 1'b1 && hi < 2000) begin
      if (bridge_b_q !== 1'b1) dly++;
      hi++;
      tick(1);
    end
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    sys_rst = 1'b1; power_en = 1'b0; take = 1'b0; mode_req = PSPC_REQ_PING;
    period_cycles = 10'h0320; cell_req = '0; coil_busy = '0;
    target_ma = '0; level_ma = '0; err_total = 0; checked = 0;
    tick(16);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(2);
    check({damping_switch_q, transition_switch_q, limit_active_q}, 3'b100);
    check(phase_q, 15'h4650);
    check(coil_en_q, 8'h00);
    sense(16'h0FA0);
    check(phase_q, 15'h4650);
    @(posedge core_clk);
    power_en <= 1'b1;
    cell_req <= '{pair: 1'b0, index: 3'h2};
    tick(4);
    check({damping_switch_q, transition_switch_q}, 2'b10);
    check(coil_en_q, 8'h04);
    @(posedge core_clk);
    cell_req <= '{pair: 1'b1, index: 3'h2};
    tick(4);
    check(coil_en_q, 8'h0C);
    @(posedge core_clk);
    coil_busy <= 8'h08;
    tick(4);
    check(coil_en_q, 8'h00);
    @(posedge core_clk);
    coil_busy <= 8'h00;
    cell_req  <= '{pair: 1'b1, index: 3'h7};
    tick(4);
    check(coil_en_q, 8'h80);
    @(posedge core_clk);
    cell_req <= '{pair: 1'b0, index: 3'h2};
    edges();
    edges();
    check(hi, 400);
    check(dly, 399);
    check(bridge_b_fine_q, 2'h3);
    @(posedge core_clk);
    period_cycles <= 10'h02BC;
    edges();
    edges();
    check(hi, 370);
    step(1'b0, 16'h2328, 16'h0BB9, 15'h3E80, 1'b1);
    step(1'b0, 16'h0DAC, 16'h0BB8, 15'h4074, 1'b0);
    step(1'b0, 16'h2328, 16'h0000, 15'h4650, 1'b0);
    step(1'b0, 16'h0000, 16'h0BB7, 15'h3E80, 1'b0);
    step(1'b1, 16'h0FA0, 16'h1194, 15'h3C8C, 1'b0);
    step(1'b1, 16'h0FA0, 16'h1389, 15'h34BC, 1'b1);
    @(posedge core_clk);
    mode_req <= PSPC_REQ_XFER;
    tick(4);
    check(transition_switch_q, 1'b1);
    tick(805);
    check({damping_switch_q, transition_switch_q}, 2'b00);
    @(posedge core_clk);
    mode_req <= PSPC_REQ_TRANS;
    tick(3);
    check({damping_switch_q, transition_switch_q}, 2'b11);
    @(posedge core_clk);
    mode_req <= PSPC_REQ_PING;
    tick(3);
    check({damping_switch_q, transition_switch_q}, 2'b10);
    @(posedge core_clk);
    power_en <= 1'b0;
    tick(3);
    check(phase_q, 15'h4650);
    check({damping_switch_q, transition_switch_q, limit_active_q}, 3'b100);
    report_and_stop();
  end
endmodule
